// file: hw/dpwm_top.sv
// Dual pulse-width modulator with two 8-bit time-bases
// Notes on behaviour
// - Channel one period (limit A+1) times 4Tosc
// - Select bit 5 picks channel two time-base
// - No 16-bit chaining while a channel runs
// - Duty is high byte plus low bits 7:6
// - Output high for duty times Tosc
// - Zero duty keeps output low
// - High byte equal period: short low tail
// - High byte above period gives full duty
// - Writes go to master latches only
// - Rollover loads slaves and sets output high if new duty is nonzero
// - Duty reads return slave latches
// - Match then clear raises timer event
// - Separate sticky rollover flags, software clears
// - Channels run on internal or external clock
// - External clock sampled once per instruction cycle
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module dpwm_top (
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic [dpwm_pkg::ADDR_W-1:0] addr,
	input  wire logic [7:0]                  wdata,
	input  wire logic                        wr_en,
	input  wire logic                        rd_en,
	input  wire logic                        external_timebase_clock,
	output logic      [7:0]                  rdata,
	output logic                             modulator_channel_one,
	output logic                             modulator_channel_two,
	output logic                             rollover_flag_a,
	output logic                             rollover_flag_b
);
	typedef struct packed {
		logic [1:0] phase;
		logic [7:0] timebase_counter_a;
		logic [7:0] timebase_counter_b;
		logic [7:0] period_limit_a;
		logic [7:0] period_limit_b;
		logic [6:0] control;
		logic       rollover_flag_a;
		logic       rollover_flag_b;
		logic       ext_meta;
		logic       ext_sync;
		logic       ext_sample;
		logic       ext_prev;
		logic [7:0] rdata;
	} dpwm_state_t;

	dpwm_state_t st;
	dpwm_state_t next_st;

	logic       wr_pa;
	logic       wr_pb;
	logic       wr_ca;
	logic       wr_cb;
	logic       wr_ctl;
	logic       wr_flags;
	logic       wr_d1h;
	logic       wr_d1l;
	logic       wr_d2h;
	logic       wr_d2l;
	logic       instr_tick;
	logic       ext_edge;
	logic       chained;
	logic       step_a;
	logic       step_b;
	logic       roll_a;
	logic       roll_b;
	logic       chan_two_timebase_select;
	logic       roll_two;
	logic [7:0] count_two;
	logic [7:0] d1_high;
	logic [7:0] d1_low;
	logic [7:0] d2_high;
	logic [7:0] chan_two_duty_low;
	logic       out_one;
	logic       out_two;
	logic       any_pwm;

	assign wr_pa    = wr_en && addr == dpwm_pkg::REG_PERIOD_A;
	assign wr_pb    = wr_en && addr == dpwm_pkg::REG_PERIOD_B;
	assign wr_ca    = wr_en && addr == dpwm_pkg::REG_COUNT_A;
	assign wr_cb    = wr_en && addr == dpwm_pkg::REG_COUNT_B;
	assign wr_ctl   = wr_en && addr == dpwm_pkg::REG_CONTROL;
	assign wr_flags = wr_en && addr == dpwm_pkg::REG_FLAGS;
	assign wr_d1h   = wr_en && addr == dpwm_pkg::REG_DUTY1_HIGH;
	assign wr_d1l   = wr_en && addr == dpwm_pkg::REG_DUTY1_LOW;
	assign wr_d2h   = wr_en && addr == dpwm_pkg::REG_DUTY2_HIGH;
	assign wr_d2l   = wr_en && addr == dpwm_pkg::REG_DUTY2_LOW;

	// One instruction cycle per four clocks
	assign instr_tick = st.phase == dpwm_pkg::PHASE_LAST;
	// Rising edge seen between two instruction-cycle samples
	assign ext_edge = st.ext_sample && !st.ext_prev;

	assign any_pwm = st.control[dpwm_pkg::CTL_EN_ONE]
		|| st.control[dpwm_pkg::CTL_EN_TWO];
	// Chaining request is ignored while a channel runs
	assign chained = st.control[dpwm_pkg::CTL_CHAIN] && !any_pwm;

	localparam int unsigned NUM_TB   = 2;
	localparam int unsigned NUM_CHAN = 2;

	logic [NUM_TB-1:0]      tb_run;
	logic [NUM_TB-1:0]      tb_ext;
	logic [NUM_TB-1:0][7:0] tb_count;
	logic [NUM_TB-1:0][7:0] tb_limit;
	logic [NUM_TB-1:0]      tb_step;
	logic [NUM_TB-1:0]      tb_roll;

	assign tb_run   = {st.control[dpwm_pkg::CTL_RUN_B],
		st.control[dpwm_pkg::CTL_RUN_A]};
	assign tb_ext   = {st.control[dpwm_pkg::CTL_EXT_B],
		st.control[dpwm_pkg::CTL_EXT_A]};
	assign tb_count = {st.timebase_counter_b, st.timebase_counter_a};
	assign tb_limit = {st.period_limit_b, st.period_limit_a};

	// Either clock source steps a time-base; a match clears it unless chained
	for (genvar tb = 0; tb < NUM_TB; tb++) begin : g_timebase
		assign tb_step[tb] = instr_tick && tb_run[tb]
			&& (tb_ext[tb] ? ext_edge : 1'b1);
		assign tb_roll[tb] = tb_step[tb] && !chained
			&& tb_count[tb] == tb_limit[tb];
	end

	assign step_a = tb_step[0];
	assign step_b = tb_step[1];
	assign roll_a = tb_roll[0];
	assign roll_b = tb_roll[1];

	assign chan_two_timebase_select =
		chan_two_duty_low[dpwm_pkg::SEL_BIT];
	assign roll_two  = chan_two_timebase_select ? roll_b : roll_a;
	// Channels compare the next position, so high lasts duty clocks
	assign count_two = chan_two_timebase_select ? next_st.timebase_counter_b
		: next_st.timebase_counter_a;

	always_comb begin
		next_st = st;
		next_st.phase = st.phase + 2'h1;
		// Two-flop synchroniser, then one sample per instruction cycle
		next_st.ext_meta = external_timebase_clock;
		next_st.ext_sync = st.ext_meta;
		if (instr_tick) begin
			next_st.ext_sample = st.ext_sync;
			next_st.ext_prev   = st.ext_sample;
		end

		if (chained) begin
			if (step_a) begin
				{next_st.timebase_counter_b, next_st.timebase_counter_a} =
					{st.timebase_counter_b, st.timebase_counter_a}
					+ 16'h0001;
			end
		end else begin
			if (roll_a) begin
				next_st.timebase_counter_a = 8'h00;
			end else if (step_a) begin
				next_st.timebase_counter_a = st.timebase_counter_a + 8'h01;
			end
			if (roll_b) begin
				next_st.timebase_counter_b = 8'h00;
			end else if (step_b) begin
				next_st.timebase_counter_b = st.timebase_counter_b + 8'h01;
			end
		end
		if (wr_ca) begin
			next_st.timebase_counter_a = wdata;
		end
		if (wr_cb) begin
			next_st.timebase_counter_b = wdata;
		end
		if (wr_pa) begin
			next_st.period_limit_a = wdata;
		end
		if (wr_pb) begin
			next_st.period_limit_b = wdata;
		end
		if (wr_ctl) begin
			next_st.control = wdata[6:0];
		end

		// Writing one clears a flag; a new event wins over the clear
		if (wr_flags && wdata[dpwm_pkg::FLAG_A]) begin
			next_st.rollover_flag_a = 1'b0;
		end
		if (wr_flags && wdata[dpwm_pkg::FLAG_B]) begin
			next_st.rollover_flag_b = 1'b0;
		end
		if (roll_a) begin
			next_st.rollover_flag_a = 1'b1;
		end
		if (roll_b) begin
			next_st.rollover_flag_b = 1'b1;
		end

		next_st.rdata = 8'h00;
		if (rd_en) begin
			unique case (addr)
				dpwm_pkg::REG_PERIOD_A:   next_st.rdata = st.period_limit_a;
				dpwm_pkg::REG_PERIOD_B:   next_st.rdata = st.period_limit_b;
				dpwm_pkg::REG_COUNT_A:
					next_st.rdata = st.timebase_counter_a;
				dpwm_pkg::REG_COUNT_B:
					next_st.rdata = st.timebase_counter_b;
				dpwm_pkg::REG_DUTY1_HIGH: next_st.rdata = d1_high;
				dpwm_pkg::REG_DUTY1_LOW:  next_st.rdata = d1_low;
				dpwm_pkg::REG_DUTY2_HIGH: next_st.rdata = d2_high;
				dpwm_pkg::REG_DUTY2_LOW:
					next_st.rdata = chan_two_duty_low;
				dpwm_pkg::REG_CONTROL:    next_st.rdata = {1'b0, st.control};
				dpwm_pkg::REG_FLAGS:
					next_st.rdata = {6'h00, st.rollover_flag_b,
						st.rollover_flag_a};
				default:                  next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.period_limit_a <= dpwm_pkg::PERIOD_RST;
			st.period_limit_b <= dpwm_pkg::PERIOD_RST;
		end else begin
			st <= next_st;
		end
	end

	logic [NUM_CHAN-1:0]      chan_enable;
	logic [NUM_CHAN-1:0]      chan_roll;
	logic [NUM_CHAN-1:0][7:0] chan_count;
	logic [NUM_CHAN-1:0]      chan_wr_high;
	logic [NUM_CHAN-1:0]      chan_wr_low;
	logic [NUM_CHAN-1:0][7:0] chan_slave_high;
	logic [NUM_CHAN-1:0][7:0] chan_slave_low;
	logic [NUM_CHAN-1:0]      chan_out;

	// Index 0 is channel one, always on time-base A
	assign chan_enable  = {st.control[dpwm_pkg::CTL_EN_TWO],
		st.control[dpwm_pkg::CTL_EN_ONE]};
	assign chan_roll    = {roll_two, roll_a};
	assign chan_count   = {count_two, next_st.timebase_counter_a};
	assign chan_wr_high = {wr_d2h, wr_d1h};
	assign chan_wr_low  = {wr_d2l, wr_d1l};

	for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
		dpwm_channel u_chan (
			.clk        (clk),
			.srst       (srst),
			.enable     (chan_enable[ch]),
			.rollover   (chan_roll[ch]),
			.count      (chan_count[ch]),
			.phase      (next_st.phase),
			.wr_high    (chan_wr_high[ch]),
			.wr_low     (chan_wr_low[ch]),
			.wdata      (wdata),
			.slave_high (chan_slave_high[ch]),
			.slave_low  (chan_slave_low[ch]),
			.pwm_out    (chan_out[ch])
		);
	end

	assign d1_high           = chan_slave_high[0];
	assign d1_low            = chan_slave_low[0];
	assign d2_high           = chan_slave_high[1];
	assign chan_two_duty_low = chan_slave_low[1];
	assign out_one           = chan_out[0];
	assign out_two           = chan_out[1];

	assign rdata                 = st.rdata;
	assign modulator_channel_one = out_one;
	assign modulator_channel_two = out_two;
	assign rollover_flag_a       = st.rollover_flag_a;
	assign rollover_flag_b       = st.rollover_flag_b;
endmodule : dpwm_top

// file: hw/dpwm_pkg.sv
// Constants for the dual pulse-width modulator
package dpwm_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] REG_PERIOD_A   = 4'h0;
	localparam logic [3:0] REG_PERIOD_B   = 4'h1;
	localparam logic [3:0] REG_COUNT_A    = 4'h2;
	localparam logic [3:0] REG_COUNT_B    = 4'h3;
	localparam logic [3:0] REG_DUTY1_HIGH = 4'h4;
	localparam logic [3:0] REG_DUTY1_LOW  = 4'h5;
	localparam logic [3:0] REG_DUTY2_HIGH = 4'h6;
	localparam logic [3:0] REG_DUTY2_LOW  = 4'h7;
	localparam logic [3:0] REG_CONTROL    = 4'h8;
	localparam logic [3:0] REG_FLAGS      = 4'h9;
	// Field positions
	localparam int unsigned LOW_DUTY_LSB  = 6;
	localparam int unsigned SEL_BIT       = 5;
	localparam int unsigned CTL_RUN_A     = 0;
	localparam int unsigned CTL_RUN_B     = 1;
	localparam int unsigned CTL_EXT_A     = 2;
	localparam int unsigned CTL_EXT_B     = 3;
	localparam int unsigned CTL_CHAIN     = 4;
	localparam int unsigned CTL_EN_ONE    = 5;
	localparam int unsigned CTL_EN_TWO    = 6;
	localparam int unsigned FLAG_A        = 0;
	localparam int unsigned FLAG_B        = 1;
	// Reset values
	localparam logic [7:0] PERIOD_RST  = 8'hff;
	localparam logic [7:0] BYTE_RST    = 8'h00;
	// One instruction cycle is four oscillator periods
	localparam logic [1:0] PHASE_LAST  = 2'h3;
	localparam logic [1:0] PHASE_FIRST = 2'h0;
endpackage : dpwm_pkg

// file: hw/dpwm_channel.sv
// One modulator channel: double-buffered duty and output compare
`timescale 1ns/100ps
module dpwm_channel (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       enable,
	input  wire logic       rollover,
	input  wire logic [7:0] count,
	input  wire logic [1:0] phase,
	input  wire logic       wr_high,
	input  wire logic       wr_low,
	input  wire logic [7:0] wdata,
	output logic      [7:0] slave_high,
	output logic      [7:0] slave_low,
	output logic            pwm_out
);
	typedef struct packed {
		logic [7:0] master_high;
		logic [7:0] master_low;
		logic [7:0] slave_high;
		logic [7:0] slave_low;
		logic       out;
	} dpwm_chan_t;

	dpwm_chan_t st;
	dpwm_chan_t next_st;
	logic [9:0] duty_value;
	logic [9:0] position;

	// Upper eight bits from high byte, lower two from low bits 7:6
	assign duty_value = {st.slave_high,
		st.slave_low[dpwm_pkg::LOW_DUTY_LSB +: 2]};
	assign position   = {count, phase};

	always_comb begin
		next_st = st;
		if (wr_high) begin
			next_st.master_high = wdata;
		end
		if (wr_low) begin
			next_st.master_low = wdata;
		end
		if (!enable) begin
			next_st.out = 1'b0;
		end else if (rollover) begin
			next_st.slave_high = next_st.master_high;
			next_st.slave_low  = next_st.master_low;
			next_st.out = (next_st.master_high != 8'h00)
				|| (next_st.master_low[dpwm_pkg::LOW_DUTY_LSB +: 2]
				!= 2'h0);
		end else if (st.out && position >= duty_value) begin
			// High count reaching duty gives Tosc*duty; a high byte
			// above the period never matches so output stays high
			next_st.out = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign slave_high = st.slave_high;
	assign slave_low  = st.slave_low;
	assign pwm_out    = st.out;
endmodule : dpwm_channel

// file: test/dpwm_asserts.sv
// Port-level assertions for the dual modulator
`timescale 1ns/100ps
module dpwm_asserts (
	input wire logic                        clk,
	input wire logic                        srst,
	input wire logic [dpwm_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0]                  wdata,
	input wire logic                        wr_en,
	input wire logic                        rd_en,
	input wire logic                        external_timebase_clock,
	input wire logic [7:0]                  rdata,
	input wire logic                        modulator_channel_one,
	input wire logic                        modulator_channel_two,
	input wire logic                        rollover_flag_a,
	input wire logic                        rollover_flag_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic clr_a, clr_b;
	assign clr_a = wr_en && addr == dpwm_pkg::REG_FLAGS
		&& wdata[dpwm_pkg::FLAG_A];
	assign clr_b = wr_en && addr == dpwm_pkg::REG_FLAGS
		&& wdata[dpwm_pkg::FLAG_B];
	rd_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data not idle");
	rd_unmap_a: assert property ($past(rd_en) && $past(addr) > 4'h9
		|-> rdata == 8'h00) else $error("unmapped read not zero");
	flag_a_hold_a: assert property (rollover_flag_a && !clr_a
		|=> rollover_flag_a) else $error("flag a dropped");
	flag_b_hold_a: assert property (rollover_flag_b && !clr_b
		|=> rollover_flag_b) else $error("flag b dropped");
	reset_out_a: assert property (disable iff (1'b0) srst |=>
		!modulator_channel_one && !modulator_channel_two && !rollover_flag_a
		&& !rollover_flag_b && rdata == 8'h00) else $error("reset state");
	ch1_start_a: assert property ($rose(modulator_channel_one)
		|-> rollover_flag_a) else $error("channel one rose off rollover");
	ch2_start_a: assert property ($rose(modulator_channel_two)
		|-> rollover_flag_a || rollover_flag_b) else $error("channel two rose");
	ch1_gap_a: assert property ($rose(modulator_channel_one)
		|=> (!$rose(modulator_channel_one)) [*3]) else $error("period short");
	cover property ($rose(modulator_channel_one));
	cover property ($rose(modulator_channel_two));
	cover property ($fell(rollover_flag_a));
endmodule : dpwm_asserts

bind dpwm_top dpwm_asserts i_dpwm_asserts (.clk, .srst, .addr, .wdata,
	.wr_en, .rd_en, .external_timebase_clock, .rdata, .modulator_channel_one,
	.modulator_channel_two, .rollover_flag_a, .rollover_flag_b);

// file: test/testbench.sv
// Self-checking bench for the dual modulator
`timescale 1ns/100ps
module testbench;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [3:0] ext_div = 4'h0;
	logic [7:0] rdata;
	logic       one, two, flag_a, flag_b;
	int         bad_count = 0;
	int         total_checks = 0;

	always #2 clk = ~clk;
	// External time-base: one rising edge every 16 clocks
	always @(posedge clk) ext_div <= ext_div + 4'h1;

	dpwm_top i_dpwm_top (.clk, .srst, .addr, .wdata, .wr_en, .rd_en,
		.external_timebase_clock(ext_div[3]), .rdata,
		.modulator_channel_one(one), .modulator_channel_two(two),
		.rollover_flag_a(flag_a), .rollover_flag_b(flag_b));

	task stop_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task chk(input int act, input int exp);
		total_checks++;
		if (act != exp) begin
			bad_count++;
			$display("Error at %0t: got %0d expected %0d", $time, act, exp);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		total_checks++;
		if (rdata !== e) begin
			bad_count++;
			$display("Error at %0t: read %h expected %h", $time, rdata, e);
		end
	endtask : rd

	task cnt(input bit ch, input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if ((ch ? two : one) === 1'b1) c++;
		end
	endtask : cnt

	// Clocks between two rising edges of one output
	task per_of(input bit ch, output int p);
		int i, first;
		logic q, prev;
		first = -1;
		p = 0;
		prev = 1'b1;
		for (i = 0; i < 400 && p == 0; i++) begin
			@(posedge clk);
			#1;
			q = ch ? two : one;
			if (q === 1'b1 && prev !== 1'b1) begin
				if (first < 0) first = i;
				else p = i - first;
			end
			prev = q;
		end
	endtask : per_of

	task duty_case(input logic [7:0] h, input logic [7:0] l, input int e);
		int c;
		wr(dpwm_pkg::REG_DUTY1_HIGH, h);
		wr(dpwm_pkg::REG_DUTY1_LOW, l);
		repeat (40) @(posedge clk);
		cnt(1'b0, 20, c);
		chk(c, e);
	endtask : duty_case

	task t_period;
		int p, c;
		rd(dpwm_pkg::REG_PERIOD_A, 8'hff);
		wr(dpwm_pkg::REG_PERIOD_A, 8'h04);
		wr(dpwm_pkg::REG_DUTY1_HIGH, 8'h02);
		wr(dpwm_pkg::REG_DUTY1_LOW, 8'hc0);
		rd(dpwm_pkg::REG_DUTY1_HIGH, 8'h00);
		wr(dpwm_pkg::REG_CONTROL, 8'h21);
		per_of(1'b0, p);
		chk(p, 20);
		cnt(1'b0, 20, c);
		chk(c, 11);
		rd(dpwm_pkg::REG_DUTY1_HIGH, 8'h02);
		rd(dpwm_pkg::REG_DUTY1_LOW, 8'hc0);
		rd(dpwm_pkg::REG_PERIOD_A, 8'h04);
		rd(4'hf, 8'h00);
	endtask : t_period

	task t_duty;
		duty_case(8'h00, 8'h00, 0);
		duty_case(8'h04, 8'h80, 18);
		duty_case(8'h05, 8'h00, 20);
		duty_case(8'h01, 8'h40, 5);
	endtask : t_duty

	task t_chan_two;
		int p, c;
		wr(dpwm_pkg::REG_PERIOD_B, 8'h01);
		wr(dpwm_pkg::REG_DUTY2_HIGH, 8'h01);
		wr(dpwm_pkg::REG_DUTY2_LOW, 8'h20);
		wr(dpwm_pkg::REG_CONTROL, 8'h63);
		repeat (40) @(posedge clk);
		per_of(1'b1, p);
		chk(p, 8);
		cnt(1'b1, 8, c);
		chk(c, 4);
	endtask : t_chan_two

	task t_flags;
		rd(dpwm_pkg::REG_FLAGS, 8'h03);
		wr(dpwm_pkg::REG_CONTROL, 8'h00);
		repeat (30) @(posedge clk);
		chk(int'(flag_a === 1'b1 && flag_b === 1'b1), 1);
		wr(dpwm_pkg::REG_FLAGS, 8'h03);
		rd(dpwm_pkg::REG_FLAGS, 8'h00);
		wr(dpwm_pkg::REG_CONTROL, 8'h31);
		repeat (30) @(posedge clk);
		rd(dpwm_pkg::REG_FLAGS, 8'h01);
	endtask : t_flags

	// Chaining with no channel enabled: eight run clocks, two steps
	task t_chain;
		wr(dpwm_pkg::REG_CONTROL, 8'h00);
		wr(dpwm_pkg::REG_FLAGS, 8'h03);
		wr(dpwm_pkg::REG_COUNT_A, 8'hfe);
		wr(dpwm_pkg::REG_COUNT_B, 8'h00);
		wr(dpwm_pkg::REG_CONTROL, 8'h11);
		rd(dpwm_pkg::REG_CONTROL, 8'h11);
		repeat (4) @(posedge clk);
		wr(dpwm_pkg::REG_CONTROL, 8'h00);
		rd(dpwm_pkg::REG_COUNT_A, 8'h00);
		rd(dpwm_pkg::REG_COUNT_B, 8'h01);
		rd(dpwm_pkg::REG_FLAGS, 8'h00);
	endtask : t_chain

	task t_ext;
		int p;
		wr(dpwm_pkg::REG_CONTROL, 8'h2f);
		wr(dpwm_pkg::REG_FLAGS, 8'h03);
		repeat (200) @(posedge clk);
		per_of(1'b0, p);
		chk(int'(p >= 76 && p <= 84), 1);
		chk(int'(flag_a === 1'b1), 1);
		chk(int'(flag_b === 1'b1), 1);
	endtask : t_ext

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_period;
		t_duty;
		t_chan_two;
		t_flags;
		t_chain;
		t_ext;
		stop_test;
	end

	initial begin
		#200000;
		bad_count++;
		stop_test;
	end
endmodule : testbench
